// ===== rtl/afs_ctrl.sv
`timescale 1ns/1ps
module afs_ctrl #(
  parameter int unsigned OUT_PERIOD = afs_pkg::OUT_PERIOD_CYC,
  parameter int unsigned PULSE_CYC  = afs_pkg::UPD_PULSE_CYC,
  parameter int unsigned CNT_W      = 16
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        reset_n,
  // Master clock input and output
  input  wire logic                        mclk_in,
  output logic                             mclk_out,
  // Setup register write from serial port
  input  wire logic                        setup_wr,
  input  wire logic [afs_pkg::SETUP_W-1:0] setup_wdata,
  output logic [afs_pkg::SETUP_W-1:0]      setup_q,
  // Data register
  input  wire logic                        data_rd,
  input  wire logic [afs_pkg::DATA_W-1:0]  filt_word,
  output logic [afs_pkg::DATA_W-1:0]       data_q,
  // Filter and modulator control
  output logic                             filter_sync_hold,
  output logic                             filt_reset,
  output logic                             sample_en,
  output logic                             data_load,
  // Status
  output logic                             data_ready_n
);

  localparam logic [CNT_W-1:0] PERIOD_L = CNT_W'(OUT_PERIOD);
  localparam logic [CNT_W-1:0] PULSE_L  = CNT_W'(PULSE_CYC);
  localparam logic [1:0]       SETTLE_L = 2'(afs_pkg::SETTLE_PERIODS);

  afs_pkg::afs_state_t state_reg;
  logic [1:0]          settle_reg;
  logic                unread_reg;
  logic                pulse_reg;
  logic [CNT_W-1:0]    pulse_cnt_reg;
  logic                period_done;
  logic                pulse_done;
  logic                dev_rst;
  logic                acc_ok;
  logic                sync_bit;
  logic                sync_fall;
  logic                running;

  // Reset input acts as a level: every register held in reset while low
  assign dev_rst  = srst || !reset_n;
  assign acc_ok   = !dev_rst;
  assign sync_bit = setup_q[afs_pkg::SETUP_FILTER_SYNC_HOLD_BIT];
  assign sync_fall = acc_ok && setup_wr && sync_bit
                     && !setup_wdata[afs_pkg::SETUP_FILTER_SYNC_HOLD_BIT];
  assign running  = state_reg != afs_pkg::AFS_HOLD;

  // Master clock passes straight through, untouched by any reset
  assign mclk_out = mclk_in;

  // Setup register; only reset and the serial write change it, sync bit included
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      setup_q <= afs_pkg::SETUP_RST_VAL;
    end else if (setup_wr) begin
      setup_q <= setup_wdata;
    end
  end

  // Output period counter, restarted whenever the filter is reset
  afs_cnt #(
    .W (CNT_W)
  ) u_period (
    .clk     (clk),
    .srst    (dev_rst),
    .run     (running && !sync_bit),
    .restart (sync_fall),
    .limit   (PERIOD_L),
    .done    (period_done)
  );

  // Filter state: hold, settle for three periods, then free run
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      state_reg  <= afs_pkg::AFS_SETTLE;
      settle_reg <= '0;
    end else if (sync_bit && !sync_fall) begin
      state_reg  <= afs_pkg::AFS_HOLD;
      settle_reg <= '0;
    end else if (sync_fall) begin
      state_reg  <= afs_pkg::AFS_SETTLE;
      settle_reg <= '0;
    end else begin
      unique case (state_reg)
        afs_pkg::AFS_HOLD: begin
          state_reg <= afs_pkg::AFS_SETTLE;
        end
        afs_pkg::AFS_SETTLE: begin
          if (period_done) begin
            if (settle_reg == SETTLE_L - 2'h1) begin
              state_reg <= afs_pkg::AFS_RUN;
            end
            settle_reg <= settle_reg + 2'h1;
          end
        end
        afs_pkg::AFS_RUN: begin
          state_reg <= afs_pkg::AFS_RUN;
        end
      endcase
    end
  end

  // A word is loaded at each period end once settled, first at settle end
  assign data_load = period_done && !sync_bit && (state_reg ==
    afs_pkg::AFS_RUN || (state_reg == afs_pkg::AFS_SETTLE &&
    settle_reg == SETTLE_L - 2'h1));
  assign filter_sync_hold = sync_bit;
  assign filt_reset = dev_rst || sync_bit;
  assign sample_en  = !filt_reset && running;

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      data_q <= '0;
    end else if (data_load) begin
      data_q <= filt_word;
    end
  end

  // Unread flag: update sets, read clears; update wins a tie
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      unread_reg <= 1'b0;
    end else if (data_load) begin
      unread_reg <= 1'b1;
    end else if (data_rd) begin
      unread_reg <= 1'b0;
    end
  end

  // Short high pulse when a word replaces one still unread
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      pulse_reg     <= 1'b0;
      pulse_cnt_reg <= '0;
    end else if (data_load && unread_reg) begin
      pulse_reg     <= 1'b1;
      pulse_cnt_reg <= '0;
    end else if (pulse_reg) begin
      if (pulse_done) begin
        pulse_reg <= 1'b0;
      end
      pulse_cnt_reg <= pulse_cnt_reg + CNT_W'(1);
    end
  end

  assign pulse_done = pulse_cnt_reg == PULSE_L - CNT_W'(1);

  // Sync does not touch unread, so a low line stays low through release
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      data_ready_n <= 1'b1;
    end else begin
      data_ready_n <= !(unread_reg && !pulse_reg) || data_rd;
    end
  end

endmodule // afs_ctrl

// ===== rtl/afs_pkg.sv
package afs_pkg;

  // Master clock 20 MHz, period in ns
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Default output word period in master clock cycles (plain default)
  localparam int unsigned OUT_PERIOD_CYC = 1024;

  // Filter settling: three output-rate periods
  localparam int unsigned SETTLE_PERIODS = 3;

  // Data-ready high pulse on update while unread: 500 master clock periods
  localparam int unsigned UPD_PULSE_CYC = 500;

  // Output data word width
  localparam int unsigned DATA_W = 16;

  // Setup register layout: filter-sync bit and the other setup fields
  localparam int unsigned SETUP_W = 8;
  localparam int unsigned SETUP_FILTER_SYNC_HOLD_BIT = 0;
  localparam logic [7:0] SETUP_RST_VAL = 8'h00;

  typedef enum logic [1:0] {
    AFS_HOLD,
    AFS_SETTLE,
    AFS_RUN
  } afs_state_t;

endpackage

// ===== rtl/afs_cnt.sv
`timescale 1ns/1ps
// Period counter: pulses done when count reaches limit - 1; restart reloads.
module afs_cnt #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Control
  input  wire logic         run,
  input  wire logic         restart,
  input  wire logic [W-1:0] limit,
  // Status
  output logic              done
);

  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (srst || restart || !run) begin
      cnt_reg <= '0;
    end else if (cnt_reg == limit - W'(1)) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

  assign done = run && !restart && (cnt_reg == limit - W'(1));

endmodule // afs_cnt

// ===== test/afs_src.sv
`timescale 1ns/1ps
module afs_src (
  // Clock
  input wire logic         clk,
  // Filter result
  output logic      [15:0] filt_word
);
  // Word moves every cycle so a stale or early load is visible
  initial filt_word = 16'h1234;
  always @(posedge clk) filt_word <= filt_word + 16'h3C5B;
endmodule // afs_src

// ===== test/afs_ctrl_sva.sv
`timescale 1ns/1ps
module afs_ctrl_chk #(
  parameter int unsigned OUT_PERIOD = afs_pkg::OUT_PERIOD_CYC
) (
  // Clock and resets
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        reset_n,
  // Master clock pins
  input wire logic        mclk_in,
  input wire logic        mclk_out,
  // Setup and data access
  input wire logic        setup_wr,
  input wire logic [7:0]  setup_wdata,
  input wire logic [7:0]  setup_q,
  input wire logic        data_rd,
  input wire logic [15:0] filt_word,
  input wire logic [15:0] data_q,
  // Filter control and status
  input wire logic        filter_sync_hold,
  input wire logic        filt_reset,
  input wire logic        sample_en,
  input wire logic        data_load,
  input wire logic        data_ready_n
);
  int unsigned cnt_reg;
  // Cycles since sync release or reset, saturating; plain setup writes
  // do not restart the filter, so they must not restart this count
  always_ff @(posedge clk) begin
    if (srst || !reset_n || filter_sync_hold)
      cnt_reg <= 0;
    else if (cnt_reg < 4000)
      cnt_reg <= cnt_reg + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !reset_n);
  hold_filter_a: assert property (
    filter_sync_hold |-> filt_reset && !sample_en && !data_load)
    else $error("filter not held");
  release_run_a: assert property (
    setup_wr && !setup_wdata[0] |=> sample_en) else $error("no resume");
  setup_keep_a: assert property (
    setup_wr |=> setup_q == $past(setup_wdata)) else $error("setup lost");
  settle_load_a: assert property (
    data_load |-> cnt_reg >= 3 * OUT_PERIOD - 1) else $error("early load");
  unread_keep_a: assert property (
    setup_wr && !data_ready_n && !data_rd && !data_load |=> !data_ready_n)
    else $error("unread flag cleared");
  pulse_len_a: assert property (
    data_load && !data_ready_n |=> ##1 data_ready_n [*8] ##1 !data_ready_n)
    else $error("bad update pulse");
  read_clear_a: assert property (
    data_rd && !data_load |=> data_ready_n) else $error("read kept low");
  fall_settled_a: assert property (
    $fell(data_ready_n) |-> cnt_reg >= 3 * OUT_PERIOD)
    else $error("ready before settling");
  word_load_a: assert property (
    data_load |=> data_q == $past(filt_word)) else $error("bad word");
  reset_state_a: assert property (disable iff (1'b0)
    srst || !reset_n |=> data_ready_n && setup_q == 8'h00 && !data_load)
    else $error("reset state wrong");
  clock_out_a: assert property (disable iff (1'b0)
    mclk_out == mclk_in) else $error("clock out broken");
endmodule // afs_ctrl_chk
bind afs_ctrl afs_ctrl_chk #(.OUT_PERIOD(OUT_PERIOD)) chk_u (
  .clk(clk), .srst(srst), .reset_n(reset_n), .mclk_in(mclk_in),
  .mclk_out(mclk_out), .setup_wr(setup_wr), .data_rd(data_rd),
  .filter_sync_hold(filter_sync_hold), .filt_reset(filt_reset),
  .sample_en(sample_en), .data_load(data_load), .data_q(data_q),
  .data_ready_n(data_ready_n), .setup_wdata(setup_wdata),
  .setup_q(setup_q), .filt_word(filt_word));

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int P = 16;
  localparam int PW = 8;
  logic        clk = 0, srst = 1, reset_n = 1, mclk_in = 0, mclk_out;
  logic        setup_wr = 0, data_rd = 0, data_load, data_ready_n;
  logic        filter_sync_hold, filt_reset, sample_en;
  logic [7:0]  setup_wdata = 8'h00, setup_q;
  logic [15:0] filt_word, data_q;
  int          n_errors = 0, samples_checked = 0, cyc = 0, n;
  // Row: written setup byte, then hold, filter reset, run, ready_n
  logic [11:0] rows [4] = '{12'hA5C, 12'h5A2, 12'hFFC, 12'h3C2};
  always #25 clk = ~clk;
  always @(posedge clk) begin
    mclk_in <= ~mclk_in;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end
  afs_src src_u (.clk(clk), .filt_word(filt_word));
  afs_ctrl #(.OUT_PERIOD(P), .PULSE_CYC(PW)) dut_u (
    .clk(clk), .srst(srst), .reset_n(reset_n), .mclk_in(mclk_in),
    .mclk_out(mclk_out), .setup_wr(setup_wr), .setup_wdata(setup_wdata),
    .setup_q(setup_q), .data_rd(data_rd), .filt_word(filt_word),
    .data_q(data_q), .filter_sync_hold(filter_sync_hold),
    .filt_reset(filt_reset), .sample_en(sample_en),
    .data_load(data_load), .data_ready_n(data_ready_n));
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    samples_checked++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("[ERR] %0t delay %0d cycles", $time, g);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    setup_wr = 1;
    setup_wdata = d;
    step;
    setup_wr = 0;
    step;
  endtask
  task automatic rd;
    data_rd = 1;
    step;
    data_rd = 0;
    step;
  endtask
  // Bounded wait for ready_n to reach v, cycles waited in n
  task automatic wait_lvl(input logic v);
    n = 0;
    while (data_ready_n !== v && n < 200) begin
      step;
      n++;
    end
  endtask
  task close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) step;
    srst = 0;
    wait_lvl(0);
    chk_rng(n, 3 * P - 3, 3 * P + 1);
    foreach (rows[i]) begin
      wr(rows[i][11:4]);
      chk(setup_q, rows[i][11:4]);
      chk({filter_sync_hold, filt_reset, sample_en, data_ready_n},
          rows[i][3:0]);
    end
    wait_lvl(1);
    chk_rng(n, 3 * P - 3, 3 * P + 1);
    wait_lvl(0);
    chk_rng(n, PW - 1, PW + 1);
    repeat (2) begin
      wr(8'h01);
      wr(8'h00);
      chk(data_ready_n, 0);
      rd;
      chk(data_ready_n, 1);
      wait_lvl(0);
      chk_rng(n, 3 * P - 5, 3 * P + 1);
    end
    reset_n = 0;
    wr(8'hC3);
    chk({setup_q, 7'h00, data_ready_n}, 16'h0001);
    chk(data_q, 16'h0000);
    chk(mclk_out, mclk_in);
    n = mclk_out;
    step;
    chk(mclk_out, !n[0]);
    reset_n = 1;
    wait_lvl(0);
    chk_rng(n, 3 * P - 3, 3 * P + 1);
    // Controller sets the part up again after a reset
    wr(8'hA4);
    chk(setup_q, 8'hA4);
    rd;
    wr(8'h01);
    wr(8'h00);
    chk(data_ready_n, 1);
    wait_lvl(0);
    chk_rng(n, 3 * P - 3, 3 * P + 1);
    close_out();
  end
endmodule // tb
